// ==== logic/backoff_pkg.sv ====
package backoff_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_LINK = 8'h04;
   localparam logic [7:0] ADDR_BASE = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_STATE = 8'h10;
   localparam logic [7:0] ADDR_NEXT = 8'h14;
   localparam logic [7:0] ADDR_CFG = 8'h18;
   // Command word and status word fields
   localparam int CW_CHAIN_END = 31;
   localparam int CW_HOLD_AFTER = 30;
   localparam int CW_DONE_ALERT = 29;
   localparam int CW_CMD_HI = 18;
   localparam int CW_CMD_LO = 16;
   localparam int SW_DONE = 15;
   localparam int SW_GOOD = 13;
   localparam int SW_FAIL = 11;
   localparam logic [2:0] CMD_DIAGNOSE = 3'h7;
   // Control register fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_HALT_ON_SUSPEND = 1;
   localparam logic [31:0] CMD_RESET = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   // Backoff settings: slot length, linear priority, exponent priority, method
   localparam logic [3:0] SLOT_TEST = 4'h3;
   localparam logic [2:0] LIN_TEST = 3'h6;
   localparam logic [3:0] EXP_TEST = 4'h3;
   localparam logic METHOD_TEST = 1'h0;
   localparam logic [11:0] CFG_RESET = 12'h000;
   // Counter widths and seeds
   localparam logic [29:0] LFSR_SEED = 30'h0000_0400;
   localparam logic [9:0] BO_ONES = 10'h3FF;
   localparam logic [9:0] BO_ZERO = 10'h000;
   localparam logic [10:0] SLOT_ZERO = 11'h000;
   localparam logic [10:0] SLOT_STOP = 11'h400;
   localparam logic [3:0] COLL_ZERO = 4'h0;
   localparam logic [3:0] COLL_ONES = 4'hF;
   localparam logic [4:0] P2_LIMIT = 5'h10;
   localparam logic [4:0] P2_ZERO = 5'h00;
   localparam logic [3:0] SHIFT_MAX = 4'hA;
   localparam int P1_STEPS = 1023;

   // Maximal-length 30-bit feedback: x^30 + x^6 + x^4 + x + 1
   function automatic logic [29:0] lfsr_next(input logic [29:0] s);
      return {s[28:0], s[29] ^ s[5] ^ s[3] ^ s[0]};
   endfunction

   function automatic logic [29:0] lfsr_after(input int n);
      logic [29:0] s;
      s = LFSR_SEED;
      for (int i = 0; i < n; i++) begin
         s = lfsr_next(s);
      end
      return s;
   endfunction

   // State reached one step before all counters wrap together
   localparam logic [29:0] LFSR_TERMINAL = lfsr_after(P1_STEPS);

   typedef enum logic [1:0] {
      ENG_IDLE = 2'b00,
      ENG_ACTIVE = 2'b01,
      ENG_SUSPENDED = 2'b10
   } engine_state_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_P1_CLEAR = 4'b0001,
      ST_P1_RUN = 4'b0010,
      ST_P1_CHECK = 4'b0011,
      ST_P2_CLEAR = 4'b0100,
      ST_P2_WAIT = 4'b0101,
      ST_P2_HIT = 4'b0110,
      ST_FINISH = 4'b0111
   } test_state_t;
endpackage

// ==== logic/backoff_self_test.sv ====
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - Command field 111 runs the self-test
// - Chain end: go idle, raise halt/idle
// - Hold after: suspend, halt only if enabled
// - Done alert raises done event, else none
// - Software clears done; device sets it
// - Good one means error-free execution
// - Fail bit: zero pass, one failure
// - Next block address is base plus link
// - Start test, wait, write done/good/fail
// - Test covers LFSR, counters, shift, mask
// - Two phases: counters, then trigger logic
// - Phase one resets everything in one cycle
// - Shift register all ones at LFSR low ones
// - Phase one stops at LFSR terminal state
// - Slot counter steps 3FF to 400 there
// - Pass only if counter low bits zero
// - Phase two resets and loads test settings
// - Emulate collisions until shift MSB sets
module backoff_self_test
   import backoff_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic done_event,
   output logic halt_event,
   output logic idle_event,
   output logic [1:0] engine_state
);

   // Reset release synchroniser; assertion is immediate
   // Nothing but the second flop feeds the rest of the design
   logic [1:0] rst_sync;
   logic rst_n;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Software-visible registers
   logic [31:0] cmd_word;
   logic [31:0] link_field;
   logic [31:0] base_addr;
   logic [31:0] next_block_addr;
   logic halt_on_suspend;
   logic [11:0] normal_cfg;
   engine_state_t eng_state;
   test_state_t tst;
   // Working backoff settings: software's copy, or the test values in phase two
   logic [3:0] slot_len;
   logic [2:0] linear_priority_setting;
   logic [3:0] exponent_priority_setting;
   logic bo_method;

   // Bus address phase capture
   logic wr_pend;
   logic [7:0] wr_addr;
   logic addr_phase;

   assign addr_phase = hsel & hready & htrans[1];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend <= 1'b0;
         wr_addr <= ADDR_CMD;
      end else begin
         wr_pend <= addr_phase & hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   // Zero-wait slave: always ready, always OKAY
   // Held low in reset so a master waits out the synchroniser
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Read data registered at the address phase; unmapped reads zero
   // Limitation: a read right behind a write to the same register
   // returns the value from before that write
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= WORD_ZERO;
      end else if (addr_phase && !hwrite) begin
         unique case (haddr[7:0])
            ADDR_CMD: hrdata <= cmd_word;
            ADDR_LINK: hrdata <= link_field;
            ADDR_BASE: hrdata <= base_addr;
            ADDR_CTRL: hrdata <= {30'h0000_0000, halt_on_suspend, 1'b0};
            // Working settings shown too, so a value stuck from the test is seen
            ADDR_STATE: begin
               hrdata <= {12'h000, bo_method, exponent_priority_setting, linear_priority_setting, slot_len, tst, 2'b00,
                          eng_state};
            end
            ADDR_NEXT: hrdata <= next_block_addr;
            ADDR_CFG: hrdata <= {20'h0_0000, normal_cfg};
            default: hrdata <= WORD_ZERO;
         endcase
      end
   end

   logic go_req;
   logic test_done;
   logic test_pass;

   // GO is a write-one pulse and always reads back as zero
   assign go_req = wr_pend && (wr_addr == ADDR_CTRL) && hwdata[CTRL_GO];

   // Plain software registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_field <= WORD_ZERO;
         base_addr <= WORD_ZERO;
         halt_on_suspend <= 1'b0;
         normal_cfg <= CFG_RESET;
      end else if (wr_pend) begin
         if (wr_addr == ADDR_LINK) begin
            link_field <= hwdata;
         end
         if (wr_addr == ADDR_BASE) begin
            base_addr <= hwdata;
         end
         if (wr_addr == ADDR_CTRL) begin
            halt_on_suspend <= hwdata[CTRL_HALT_ON_SUSPEND];
         end
         if (wr_addr == ADDR_CFG) begin
            normal_cfg <= hwdata[11:0];
         end
      end
   end

   // Command block word; a completing block wins over a software write
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_word <= CMD_RESET;
      end else if (test_done && eng_state == ENG_ACTIVE) begin
         cmd_word[SW_DONE] <= 1'b1;
         cmd_word[SW_GOOD] <= test_pass;
         cmd_word[SW_FAIL] <= ~test_pass;
      end else if (wr_pend && wr_addr == ADDR_CMD && eng_state != ENG_ACTIVE) begin
         cmd_word <= hwdata;
      end
   end

   // Engine: go starts a block from idle or suspended; busy ignores go
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         eng_state <= ENG_IDLE;
         done_event <= 1'b0;
         halt_event <= 1'b0;
         idle_event <= 1'b0;
         next_block_addr <= WORD_ZERO;
      end else begin
         // Events are one-cycle pulses unless set again below
         done_event <= 1'b0;
         halt_event <= 1'b0;
         idle_event <= 1'b0;
         unique case (eng_state)
            // A suspended chain resumes by the same GO as an idle one
            ENG_IDLE, ENG_SUSPENDED: begin
               if (go_req) begin
                  eng_state <= ENG_ACTIVE;
               end
            end
            // Everything settles on the completion strobe, in one edge
            ENG_ACTIVE: begin
               if (test_done) begin
                  next_block_addr <= base_addr + link_field;
                  done_event <= cmd_word[CW_DONE_ALERT];
                  if (cmd_word[CW_CHAIN_END]) begin
                     // Chain end outranks hold-after and always reports
                     eng_state <= ENG_IDLE;
                     halt_event <= 1'b1;
                     idle_event <= 1'b1;
                  end else if (cmd_word[CW_HOLD_AFTER]) begin
                     eng_state <= ENG_SUSPENDED;
                     halt_event <= halt_on_suspend;
                  end else begin
                     // Next block fetch is outside this block; rest idle
                     eng_state <= ENG_IDLE;
                  end
               end
            end
            default: eng_state <= ENG_IDLE;
         endcase
      end
   end

   assign engine_state = eng_state;

   // Backoff datapath under test
   logic [29:0] lfsr;
   logic [9:0] bo_cnt;
   logic [10:0] slot_cnt;
   logic [3:0] coll_cnt;
   logic [9:0] bo_shift;
   // Phase bookkeeping
   logic [4:0] p2_iter;
   logic p1_ok;
   logic is_diag;
   logic [9:0] bo_mask;
   logic [3:0] mask_width;
   logic [4:0] mask_sum;
   logic [3:0] wait_len;

   assign is_diag = (cmd_word[CW_CMD_HI:CW_CMD_LO] == CMD_DIAGNOSE);
   // Mask opens one more bit per collision, offset by exponent priority
   assign mask_sum = {1'b0, coll_cnt} + {1'b0, exponent_priority_setting};
   // Window saturates at the shift register's width
   assign mask_width = (mask_sum > {1'b0, SHIFT_MAX}) ? SHIFT_MAX : mask_sum[3:0];
   assign bo_mask = ~(BO_ONES << mask_width);
   // Linear priority stretches the wait unless the method is exponential-only
   // Test settings give 3 + 6; normal settings only matter outside the test
   assign wait_len = bo_method ? slot_len : slot_len + {1'b0, linear_priority_setting};

   // Self-test sequencer, phase one then phase two
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tst <= ST_IDLE;
         lfsr <= LFSR_SEED;
         bo_cnt <= BO_ZERO;
         slot_cnt <= SLOT_ZERO;
         coll_cnt <= COLL_ZERO;
         bo_shift <= BO_ZERO;
         p2_iter <= P2_ZERO;
         p1_ok <= 1'b1;
         test_done <= 1'b0;
         test_pass <= 1'b0;
      end else begin
         test_done <= 1'b0;
         unique case (tst)
            // Starts on the same GO that the engine accepts
            ST_IDLE: begin
               if (go_req && eng_state != ENG_ACTIVE) begin
                  // Other commands finish at once and report not good
                  tst <= is_diag ? ST_P1_CLEAR : ST_FINISH;
                  test_pass <= 1'b0;
               end
            end
            // Common reset: every counter starts in the same cycle
            ST_P1_CLEAR: begin
               lfsr <= LFSR_SEED;
               bo_cnt <= BO_ZERO;
               slot_cnt <= SLOT_ZERO;
               coll_cnt <= COLL_ZERO;
               bo_shift <= BO_ZERO;
               p1_ok <= 1'b1;
               tst <= ST_P1_RUN;
            end
            ST_P1_RUN: begin
               // All counters advance together from the common reset
               lfsr <= lfsr_next(lfsr);
               bo_cnt <= bo_cnt + 10'h001;
               slot_cnt <= slot_cnt + 11'h001;
               coll_cnt <= coll_cnt + 4'h1;
               bo_shift <= {bo_shift[8:0], 1'b1};
               if (lfsr[9:0] == BO_ONES && bo_shift != BO_ONES) begin
                  p1_ok <= 1'b0;
               end
               if (lfsr == LFSR_TERMINAL) begin
                  // Counters must be at their wrap points here
                  if (bo_cnt != BO_ONES || coll_cnt != COLL_ONES
                      || slot_cnt != SLOT_STOP - 11'h001) begin
                     p1_ok <= 1'b0;
                  end
                  tst <= ST_P1_CHECK;
               end else if (bo_cnt == BO_ONES && slot_cnt[10]) begin
                  // Terminal state missed a full period: broken LFSR
                  p1_ok <= 1'b0;
                  tst <= ST_P1_CHECK;
               end
            end
            // Judge what the common wrap left behind
            ST_P1_CHECK: begin
               if (p1_ok && bo_cnt == BO_ZERO && slot_cnt[9:0] == BO_ZERO
                   && coll_cnt == COLL_ZERO && slot_cnt == SLOT_STOP) begin
                  tst <= ST_P2_CLEAR;
               end else begin
                  test_pass <= 1'b0;
                  tst <= ST_FINISH;
               end
            end
            // Trigger test starts from a clean datapath
            ST_P2_CLEAR: begin
               lfsr <= LFSR_SEED;
               bo_cnt <= BO_ZERO;
               slot_cnt <= SLOT_ZERO;
               coll_cnt <= COLL_ZERO;
               bo_shift <= BO_ZERO;
               p2_iter <= P2_ZERO;
               tst <= ST_P2_WAIT;
            end
            ST_P2_WAIT: begin
               // Emulated transmission: one wait of wait_len (slot length plus linear priority) per attempt
               lfsr <= lfsr_next(lfsr);
               slot_cnt <= slot_cnt + 11'h001;
               if (slot_cnt[3:0] >= wait_len) begin
                  tst <= ST_P2_HIT;
               end
            end
            ST_P2_HIT: begin
               // Emulated collision widens the backoff window
               // The top bit can only fill if the mask keeps widening
               slot_cnt <= SLOT_ZERO;
               coll_cnt <= coll_cnt + 4'h1;
               bo_cnt <= lfsr[9:0] & bo_mask;
               bo_shift <= {bo_shift[8:0], 1'b1} & bo_mask;
               p2_iter <= p2_iter + 5'h01;
               if (bo_shift[9]) begin
                  test_pass <= 1'b1;
                  tst <= ST_FINISH;
               end else if (p2_iter == P2_LIMIT) begin
                  test_pass <= 1'b0;
                  tst <= ST_FINISH;
               end else begin
                  tst <= ST_P2_WAIT;
               end
            end
            // One-cycle strobe hands the verdict to the engine
            ST_FINISH: begin
               test_done <= 1'b1;
               tst <= ST_IDLE;
            end
            default: tst <= ST_IDLE;
         endcase
      end
   end

   // Settings are forced only during phase two, then fall back to software's
   // Reloaded on every cycle outside phase two, so a CFG write shows one cycle later
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_len <= CFG_RESET[3:0];
         linear_priority_setting <= CFG_RESET[6:4];
         exponent_priority_setting <= CFG_RESET[10:7];
         bo_method <= CFG_RESET[11];
      end else if (tst == ST_P2_CLEAR) begin
         slot_len <= SLOT_TEST;
         linear_priority_setting <= LIN_TEST;
         exponent_priority_setting <= EXP_TEST;
         bo_method <= METHOD_TEST;
      end else if (tst != ST_P2_WAIT && tst != ST_P2_HIT) begin
         slot_len <= normal_cfg[3:0];
         linear_priority_setting <= normal_cfg[6:4];
         exponent_priority_setting <= normal_cfg[10:7];
         bo_method <= normal_cfg[11];
      end
   end

endmodule

// ==== tb/host_bus_model.sv ====
`timescale 1ns/1ps
module host_bus_model
   import backoff_pkg::*;
(
   input wire logic core_clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // Bus idle from time zero; word size only
   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end

   // Reserved bits and the whole status word go out as zeros
   function automatic logic [31:0] make_cmd(input logic [2:0] flags, input logic [2:0] code);
      return {flags, 10'h000, code, 16'h0000};
   endfunction

   // One single transfer; read data is taken at the data phase edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wr ? d : ~hwdata; // Reads get a toggling pattern, not stale data
      do @(posedge core_clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule

// ==== tb/backoff_self_test_monitor.sv ====
`timescale 1ns/1ps
module backoff_self_test_monitor
   import backoff_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic done_event,
   input wire logic halt_event,
   input wire logic idle_event,
   input wire logic [1:0] engine_state
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic wr_cmd, wr_ctrl, rdy_seen, go_take, left_active;
   logic [2:0] cmd_code;
   logic [11:0] act_cnt;

   // Bus snoop: command code and GO writes, seen in the data phase
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_cmd <= 1'b0;
         wr_ctrl <= 1'b0;
         cmd_code <= 3'h0;
      end else begin
         wr_cmd <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == ADDR_CMD;
         wr_ctrl <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == ADDR_CTRL;
         if (wr_cmd && engine_state != ENG_ACTIVE) begin
            cmd_code <= hwdata[18:16];
         end
      end
   end

   // Active-cycle counter; a long run needs no long repetition
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         act_cnt <= 12'h000;
         rdy_seen <= 1'b0;
      end else begin
         act_cnt <= (engine_state == ENG_ACTIVE) ? act_cnt + 12'h001 : 12'h000;
         rdy_seen <= rdy_seen | hreadyout;
      end
   end
   assign go_take = wr_ctrl && hwdata[0] && engine_state != ENG_ACTIVE;

   property p_idle_pair;
      idle_event |-> halt_event && engine_state == ENG_IDLE && $past(engine_state) == ENG_ACTIVE;
   endproperty
   a_idle_pair: assert property (p_idle_pair) else $error("idle event without chain end");
   property p_halt_cause;
      halt_event && !idle_event |-> engine_state == ENG_SUSPENDED;
   endproperty
   a_halt_cause: assert property (p_halt_cause) else $error("halt event off suspend");
   property p_suspend_entry;
      $changed(engine_state) && engine_state == ENG_SUSPENDED
         |-> $past(engine_state) == ENG_ACTIVE;
   endproperty
   a_suspend_entry: assert property (p_suspend_entry) else $error("bad suspend entry");
   property p_done_end;
      done_event |-> $past(engine_state) == ENG_ACTIVE && engine_state != ENG_ACTIVE;
   endproperty
   a_done_end: assert property (p_done_end) else $error("done event not at block end");
   property p_pulse;
      done_event || idle_event |=> !done_event && !idle_event;
   endproperty
   a_pulse: assert property (p_pulse) else $error("event longer than one cycle");
   property p_go;
      go_take |-> ##[1:2] engine_state == ENG_ACTIVE;
   endproperty
   a_go: assert property (p_go) else $error("GO did not start the engine");
   assign left_active = engine_state != ENG_ACTIVE;
   property p_diag_long;
      $past(engine_state) == ENG_ACTIVE && left_active && cmd_code == CMD_DIAGNOSE
         |-> act_cnt >= 12'h3E8;
   endproperty
   a_diag_long: assert property (p_diag_long) else $error("self-test ended too soon");
   property p_other_short;
      $past(engine_state) == ENG_ACTIVE && left_active && cmd_code != CMD_DIAGNOSE
         |-> act_cnt <= 12'h008;
   endproperty
   a_other_short: assert property (p_other_short) else $error("other command ran a test");
   property p_bound;
      act_cnt <= 12'h7D0;
   endproperty
   a_bound: assert property (p_bound) else $error("self-test exceeded its bound");
   property p_ready;
      rdy_seen |-> hreadyout && !hresp;
   endproperty
   a_ready: assert property (p_ready) else $error("bus not ready or not OKAY");
   c_done: cover property (done_event);
   c_idle: cover property (idle_event);
   c_susp: cover property (halt_event && engine_state == ENG_SUSPENDED);
endmodule

bind backoff_self_test backoff_self_test_monitor mon (.core_clk, .rst_b, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .done_event, .halt_event,
   .idle_event, .engine_state);

// ==== tb/backoff_self_test_tb.sv ====
`timescale 1ns/1ps
module backoff_self_test_tb
   import backoff_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, done_event, halt_event, idle_event;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, engine_state;
   logic [2:0] hsize;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n_done, n_halt, n_idle;

   always #10 core_clk = ~core_clk;

   host_bus_model host (.core_clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata);
   backoff_self_test uut (.core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .done_event, .halt_event,
      .idle_event, .engine_state);

   // Count event pulses; a hang ends the run as a mismatch
   always @(posedge core_clk) begin
      cycles++;
      n_done += int'(done_event === 1'b1);
      n_halt += int'(halt_event === 1'b1);
      n_idle += int'(idle_event === 1'b1);
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      host.xfer(1'b1, a, d, q);
   endtask

   // Issue one block, wait for completion, leave the command word in rd
   task automatic run(input logic [2:0] flags, input logic [2:0] code, input logic [31:0] ctrl);
      wr(ADDR_CMD, host.make_cmd(flags, code));
      wr(ADDR_LINK, 32'h0000_1230);
      wr(ADDR_BASE, 32'h8000_0010);
      n_done = 0;
      n_halt = 0;
      n_idle = 0;
      wr(ADDR_CTRL, ctrl | 32'h0000_0001);
      for (int i = 0; i < 4 && engine_state !== ENG_ACTIVE; i++) @(posedge core_clk);
      chk("engine active", 32'h0000_0001, {30'h0, engine_state});
      for (int i = 0; i < 3000 && engine_state === ENG_ACTIVE; i++) @(posedge core_clk);
      @(posedge core_clk); // Lets the pulse counters see the completion edge
      host.xfer(1'b0, ADDR_NEXT, WORD_ZERO, rd);
      chk("next address", 32'h8000_1240, rd);
      host.xfer(1'b0, ADDR_CMD, WORD_ZERO, rd);
   endtask

   task automatic t_chain_end;
      run(3'h5, CMD_DIAGNOSE, WORD_ZERO);
      chk("status", 32'h0000_A000, rd & 32'h0000_A800);
      chk("done events", 32'h1, n_done);
      chk("halt events", 32'h1, n_halt);
      chk("idle events", 32'h1, n_idle);
      chk("state", 32'h0, {30'h0, engine_state});
   endtask

   // Normal backoff settings must survive the test's temporary ones
   task automatic t_hold;
      wr(ADDR_CFG, 32'h0000_05A3);
      run(3'h2, CMD_DIAGNOSE, 32'h0000_0002);
      chk("status", 32'h0000_A000, rd & 32'h0000_A800);
      chk("halt events", 32'h1, n_halt + n_idle);
      chk("done events", 32'h0, n_done);
      chk("state", 32'h2, {30'h0, engine_state});
      host.xfer(1'b0, ADDR_CFG, WORD_ZERO, rd);
      chk("settings", 32'h0000_05A3, rd);
      // Working settings back to software's, engine suspended, test idle
      host.xfer(1'b0, ADDR_STATE, WORD_ZERO, rd);
      chk("working settings", 32'h0005_A302, rd);
      run(3'h2, CMD_DIAGNOSE, WORD_ZERO);
      chk("halt quiet", 32'h0, n_halt);
   endtask

   task automatic t_other;
      run(3'h4, 3'h2, WORD_ZERO);
      chk("status", 32'h0000_8800, rd & 32'h0000_A800);
      chk("done events", 32'h0, n_done);
      chk("idle events", 32'h1, n_idle);
      host.xfer(1'b0, 8'h1C, WORD_ZERO, rd);
      chk("unmapped", WORD_ZERO, rd);
   endtask

   task automatic close_out;
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 8 && hreadyout !== 1'b1; i++) @(posedge core_clk);
      t_chain_end();
      t_hold();
      t_other();
      close_out();
   end
endmodule
